// ---- rtl/tts_top.sv ----
// Tare calibration control and two threshold switching outputs.
`default_nettype none
`include "tts_cfg.svh"
module tts_top
  import tts_pkg::*;
#(
  parameter int VAL_W = `TTS_VAL_W,
  parameter int QUAL_CYC = `TTS_TARE_QUAL_CYC,
  parameter int CAL_CYC = `TTS_CAL_CYC
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic tare_pin,
  input wire logic logger_en,
  input wire tts_meas_t meas_in,
  input wire logic req_offset,
  input wire logic req_zero,
  input wire tts_thr_wr_t thr_wr,
  input wire logic gf_wr,
  input wire logic [31:0] gf_val,
  input wire logic sens_wr,
  input wire logic [31:0] sens_scale,
  input wire logic unit_wr,
  input wire logic [7:0] unit_val,
  input wire logic [7:0] sg_unit_val,
  output logic switch_out_one,
  output logic switch_out_two,
  output logic tx_enable,
  output logic aout_valid,
  output logic cal_busy,
  output logic send_one,
  output logic gf_reject,
  output tts_meas_t meas_out,
  output logic [31:0] scale_out,
  output logic [7:0] unit_out
);
  localparam logic signed [VAL_W-1:0] OFS_LIM =
    VAL_W'((64'(`TTS_FULL_SCALE) * `TTS_OFS_LIMIT_PCT) / 100);
  logic tare_s1_ff;
  logic tare_s2_ff;
  logic tare_fire;
  tts_state_t st_ff;
  tts_state_t nxt_st;
  logic [23:0] cal_cnt_ff;
  logic [23:0] nxt_cal_cnt;
  logic do_ofs_ff;
  logic nxt_do_ofs;
  logic do_zero_ff;
  logic nxt_do_zero;
  logic signed [VAL_W-1:0] ofs_ff;
  logic signed [VAL_W-1:0] nxt_ofs;
  logic signed [VAL_W-1:0] zero_ff;
  logic signed [VAL_W-1:0] nxt_zero;
  logic signed [VAL_W-1:0] raw_last_ff;
  logic signed [VAL_W-1:0] nxt_raw_last;
  logic send_ff;
  logic nxt_send;
  logic signed [VAL_W-1:0] thr_on_ff [2];
  logic signed [VAL_W-1:0] thr_off_ff [2];
  logic [1:0] win_ff;
  logic [1:0] inv_ff;
  logic [1:0] act;
  logic [1:0] sw_ff;
  logic [31:0] gf_ff;
  logic [31:0] nxt_gf;
  logic [31:0] scale_ff;
  logic [31:0] nxt_scale;
  logic [7:0] unit_ff;
  logic [7:0] nxt_unit;
  logic gf_rej_ff;
  logic nxt_gf_rej;
  tts_meas_t mo_ff;
  tts_meas_t nxt_mo;
  logic signed [VAL_W:0] corr_wide;
  logic signed [VAL_W:0] lim_ofs;
  logic cal_on;
  // Two-flop synchroniser for the tare pin.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      tare_s1_ff <= 1'b0;
      tare_s2_ff <= 1'b0;
    end
    else
    begin
      tare_s1_ff <= tare_pin;
      tare_s2_ff <= tare_s1_ff;
    end
  end
  // Qualifies the tare level.
  tts_tare_qual #(
    .QUAL_CYC(QUAL_CYC)
  ) u_qual (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .tare_lvl(tare_s2_ff),
    .tare_fire(tare_fire)
  );
  assign cal_on = (st_ff == TTS_CAL);
  // Offset limited to the compensation range.
  always_comb
  begin
    lim_ofs = (VAL_W + 1)'(raw_last_ff);
    if (lim_ofs > (VAL_W + 1)'(OFS_LIM))
    begin
      lim_ofs = (VAL_W + 1)'(OFS_LIM);
    end
    else if (lim_ofs < -(VAL_W + 1)'(OFS_LIM))
    begin
      lim_ofs = -(VAL_W + 1)'(OFS_LIM);
    end
    corr_wide = (VAL_W + 1)'(meas_in.value) - (VAL_W + 1)'(ofs_ff) - (VAL_W + 1)'(zero_ff);
  end
  // Calibration sequencer, offset and zero registers, logger send.
  always_comb
  begin
    nxt_st = st_ff;
    nxt_cal_cnt = cal_cnt_ff;
    nxt_do_ofs = do_ofs_ff;
    nxt_do_zero = do_zero_ff;
    nxt_ofs = ofs_ff;
    nxt_zero = zero_ff;
    nxt_send = 1'b0;
    nxt_raw_last = meas_in.valid ? meas_in.value : raw_last_ff;
    case (st_ff)
      TTS_IDLE:
      begin
        if (tare_fire && logger_en)
        begin
          nxt_send = 1'b1;
        end
        else if (tare_fire || req_offset || req_zero)
        begin
          nxt_st = TTS_CAL;
          nxt_cal_cnt = 24'h000000;
          nxt_do_ofs = tare_fire || req_offset;
          nxt_do_zero = tare_fire || req_zero;
        end
      end
      TTS_CAL:
      begin
        if (cal_cnt_ff == 24'(CAL_CYC - 1))
        begin
          nxt_st = TTS_IDLE;
          if (do_ofs_ff)
          begin
            nxt_ofs = VAL_W'(lim_ofs);
          end
          if (do_zero_ff)
          begin
            // Zero uses the residual after the offset that is now in force.
            nxt_zero = do_ofs_ff ? VAL_W'(raw_last_ff - VAL_W'(lim_ofs)) :
              VAL_W'(raw_last_ff - ofs_ff);
          end
        end
        else
        begin
          nxt_cal_cnt = cal_cnt_ff + 24'h000001;
        end
      end
      default:
      begin
        nxt_st = TTS_IDLE;
      end
    endcase
  end
  // Corrected value stream, withheld during calibration.
  always_comb
  begin
    nxt_mo.valid = meas_in.valid && !cal_on;
    nxt_mo.value = meas_in.valid ? VAL_W'(corr_wide) : mo_ff.value;
  end
  // Scaling, gage factor and unit settings.
  always_comb
  begin
    nxt_gf = gf_ff;
    nxt_scale = scale_ff;
    nxt_unit = unit_ff;
    nxt_gf_rej = gf_rej_ff;
    if (gf_wr)
    begin
      if (gf_val >= `TTS_GF_MIN && gf_val <= `TTS_GF_MAX)
      begin
        nxt_gf = gf_val;
        nxt_scale = gf_val;
        nxt_unit = sg_unit_val;
        nxt_gf_rej = 1'b0;
      end
      else
      begin
        nxt_gf_rej = 1'b1;
      end
    end
    else if (sens_wr)
    begin
      nxt_scale = sens_scale;
    end
    else if (unit_wr)
    begin
      nxt_unit = unit_val;
    end
  end
  // Registers the sequencer and settings.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      st_ff <= TTS_IDLE;
      cal_cnt_ff <= 24'h000000;
      do_ofs_ff <= 1'b0;
      do_zero_ff <= 1'b0;
      ofs_ff <= '0;
      zero_ff <= '0;
      raw_last_ff <= '0;
      send_ff <= 1'b0;
      mo_ff <= '0;
      gf_ff <= `TTS_GF_RST;
      scale_ff <= `TTS_SCALE_RST;
      unit_ff <= `TTS_UNIT_RST;
      gf_rej_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      cal_cnt_ff <= nxt_cal_cnt;
      do_ofs_ff <= nxt_do_ofs;
      do_zero_ff <= nxt_do_zero;
      ofs_ff <= nxt_ofs;
      zero_ff <= nxt_zero;
      raw_last_ff <= nxt_raw_last;
      send_ff <= nxt_send;
      mo_ff <= nxt_mo;
      gf_ff <= nxt_gf;
      scale_ff <= nxt_scale;
      unit_ff <= nxt_unit;
      gf_rej_ff <= nxt_gf_rej;
    end
  end
  // Threshold storage and one comparator channel per output.
  for (genvar i = 0; i < 2; i++)
  begin : g_ch
    always_ff @(posedge sys_clk)
    begin
      if (!rstn)
      begin
        thr_on_ff[i] <= `TTS_THR_RST;
        thr_off_ff[i] <= `TTS_THR_RST;
        win_ff[i] <= 1'b0;
        inv_ff[i] <= 1'b0;
      end
      else if (thr_wr.valid && thr_wr.chan == 2'(i))
      begin
        case (thr_wr.field)
          TTS_SET_ON: thr_on_ff[i] <= VAL_W'(thr_wr.value);
          TTS_SET_OFF: thr_off_ff[i] <= VAL_W'(thr_wr.value);
          TTS_SET_MODE: win_ff[i] <= thr_wr.value[0];
          TTS_SET_INV: inv_ff[i] <= thr_wr.value[0];
          default: win_ff[i] <= win_ff[i];
        endcase
      end
    end
    tts_thr_chan #(
      .VAL_W(VAL_W)
    ) u_ch (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .hold(cal_on),
      .meas_valid(nxt_mo.valid),
      .meas(VAL_W'(corr_wide)),
      .thr_on(thr_on_ff[i]),
      .thr_off(thr_off_ff[i]),
      .win_mode(win_ff[i]),
      .active(act[i])
    );
    // Active low in open-collector form, inverted for open-emitter.
    always_ff @(posedge sys_clk)
    begin
      if (!rstn)
      begin
        sw_ff[i] <= 1'b1;
      end
      else
      begin
        sw_ff[i] <= ~act[i] ^ inv_ff[i];
      end
    end
  end
  // Registered outputs.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      tx_enable <= 1'b0;
      aout_valid <= 1'b0;
      cal_busy <= 1'b0;
    end
    else
    begin
      tx_enable <= !(nxt_st == TTS_CAL);
      aout_valid <= !(nxt_st == TTS_CAL);
      cal_busy <= (nxt_st == TTS_CAL);
    end
  end
  assign switch_out_one = sw_ff[0];
  assign switch_out_two = sw_ff[1];
  assign send_one = send_ff;
  assign gf_reject = gf_rej_ff;
  assign meas_out = mo_ff;
  assign scale_out = scale_ff;
  assign unit_out = unit_ff;
endmodule : tts_top
`default_nettype wire

// ---- common/tts_cfg.svh ----
// Timing counts, field widths and reset values of the tare and threshold switch.
`ifndef TTS_CFG_SVH
`define TTS_CFG_SVH
`define TTS_CLK_HZ 20000000
`define TTS_TARE_QUAL_US 8000
`define TTS_TARE_QUAL_CYC ((`TTS_TARE_QUAL_US * (`TTS_CLK_HZ / 1000000)))
`define TTS_CAL_MS 120
`define TTS_CAL_CYC ((`TTS_CAL_MS * (`TTS_CLK_HZ / 1000)))
`define TTS_VAL_W 24
`define TTS_OFS_LIMIT_PCT 120
`define TTS_FULL_SCALE 24'h3FFFFF
`define TTS_GF_MIN 32'h00000014
`define TTS_GF_MAX 32'h000064C8
`define TTS_GF_RST 32'h000000C8
`define TTS_SCALE_RST 32'h00010000
`define TTS_UNIT_RST 8'h00
`define TTS_THR_RST 24'h000000
`endif

// ---- common/tts_pkg.sv ----
// Types shared by the tare and threshold switch.
`default_nettype none
package tts_pkg;
  typedef enum logic [1:0] {
    TTS_IDLE,
    TTS_CAL
  } tts_state_t;
  typedef enum logic [1:0] {
    TTS_SET_ON,
    TTS_SET_OFF,
    TTS_SET_MODE,
    TTS_SET_INV
  } tts_thr_field_t;
  typedef struct packed {
    logic valid;
    logic [1:0] chan;
    tts_thr_field_t field;
    logic [23:0] value;
  } tts_thr_wr_t;
  typedef struct packed {
    logic valid;
    logic signed [23:0] value;
  } tts_meas_t;
endpackage : tts_pkg
`default_nettype wire

// ---- rtl/tts_tare_qual.sv ----
// Qualifies the synchronised tare level by holding it high for a minimum time.
`default_nettype none
`include "tts_cfg.svh"
module tts_tare_qual
  import tts_pkg::*;
#(
  parameter int QUAL_CYC = `TTS_TARE_QUAL_CYC
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic tare_lvl,
  output logic tare_fire
);
  logic [23:0] cnt_ff;
  logic [23:0] nxt_cnt;
  logic done_ff;
  logic nxt_done;
  // Counts high time; a low level restarts the count and one pulse fires per high period that lasts QUAL_CYC cycles.
  always_comb
  begin
    nxt_cnt = cnt_ff;
    nxt_done = done_ff;
    tare_fire = 1'b0;
    if (!tare_lvl)
    begin
      nxt_cnt = 24'h000000;
      nxt_done = 1'b0;
    end
    else if (!done_ff)
    begin
      if (cnt_ff == 24'(QUAL_CYC - 1))
      begin
        tare_fire = 1'b1;
        nxt_done = 1'b1;
      end
      else
      begin
        nxt_cnt = cnt_ff + 24'h000001;
      end
    end
  end
  // Registers the qualification state.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      cnt_ff <= 24'h000000;
      done_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end
endmodule : tts_tare_qual
`default_nettype wire

// ---- rtl/tts_thr_chan.sv ----
// One switching channel: hysteretic threshold switch or window comparator.
`default_nettype none
`include "tts_cfg.svh"
module tts_thr_chan
  import tts_pkg::*;
#(
  parameter int VAL_W = `TTS_VAL_W
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic hold,
  input wire logic meas_valid,
  input wire logic signed [VAL_W-1:0] meas,
  input wire logic signed [VAL_W-1:0] thr_on,
  input wire logic signed [VAL_W-1:0] thr_off,
  input wire logic win_mode,
  output logic active
);
  logic act_ff;
  logic nxt_act;
  assign active = act_ff;
  // Decides the relay state from each new value; frozen while a calibration runs.
  always_comb
  begin
    nxt_act = act_ff;
    if (meas_valid && !hold)
    begin
      if (win_mode)
      begin
        nxt_act = (meas <= thr_on) && (meas >= thr_off);
      end
      else if (meas > thr_on)
      begin
        nxt_act = 1'b1;
      end
      else if (meas < thr_off)
      begin
        nxt_act = 1'b0;
      end
    end
  end
  // Registers the relay state.
  always_ff @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      act_ff <= 1'b0;
    end
    else
    begin
      act_ff <= nxt_act;
    end
  end
endmodule : tts_thr_chan
`default_nettype wire

// ---- test/tts_far_side.sv ----
// Tare trigger source and relay loads at the far side of the block.
`default_nettype none
module tts_far_side
(
  input wire logic sys_clk,
  input wire logic press,
  input wire logic [7:0] press_len,
  input wire logic sw_one,
  input wire logic sw_two,
  input wire logic emit_one,
  input wire logic emit_two,
  output logic tare_pin,
  output logic relay_one,
  output logic relay_two
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] left_ff = 8'h00;
  // Holds the tare contact closed for the requested number of cycles.
  always_ff @(posedge sys_clk)
  begin
    if (press)
      left_ff <= press_len;
    else if (left_ff != 8'h00)
      left_ff <= left_ff - 8'h01;
  end
  assign tare_pin = left_ff != 8'h00;
  // A relay pulls in on a low collector pin or on a high emitter pin.
  assign relay_one = emit_one ? sw_one : !sw_one;
  assign relay_two = emit_two ? sw_two : !sw_two;
endmodule : tts_far_side
`default_nettype wire

// ---- test/tts_top_asserts.sv ----
// Concurrent checks on the ports of the tare and threshold switch.
`default_nettype none
`include "tts_cfg.svh"
module tts_top_asserts
  import tts_pkg::*;
#(
  parameter int CAL_CYC = `TTS_CAL_CYC
)
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic req_offset,
  input wire logic req_zero,
  input wire logic gf_wr,
  input wire logic [31:0] gf_val,
  input wire logic sens_wr,
  input wire logic [31:0] sens_scale,
  input wire logic unit_wr,
  input wire logic tx_enable,
  input wire logic aout_valid,
  input wire logic cal_busy,
  input wire logic send_one,
  input wire logic gf_reject,
  input wire tts_meas_t meas_out,
  input wire logic [31:0] scale_out
);
  logic [31:0] busy_cnt_ff;
  logic [31:0] nxt_busy_cnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // Counts the cycles of the running calibration.
  always_comb
  begin
    nxt_busy_cnt = cal_busy ? busy_cnt_ff + 32'h1 : 32'h0;
  end
  always_ff @(posedge sys_clk)
  begin
    busy_cnt_ff <= rstn ? nxt_busy_cnt : 32'h0;
  end
  chk_busy_tx: assert property (cal_busy |-> !tx_enable)
    else $error("transmit enabled in calibration");
  chk_busy_aout: assert property (cal_busy |-> !aout_valid)
    else $error("analogue output valid in calibration");
  chk_busy_meas: assert property (cal_busy && $past(cal_busy) |-> !meas_out.valid)
    else $error("value sent in calibration");
  chk_req_start: assert property ((req_offset || req_zero) && !cal_busy |=> cal_busy)
    else $error("serial request not started");
  chk_cal_len: assert property ($fell(cal_busy) |-> busy_cnt_ff == 32'(CAL_CYC))
    else $error("calibration length wrong");
  chk_send_pulse: assert property (send_one |-> !cal_busy ##1 (!send_one && !cal_busy))
    else $error("logger send not a single pulse");
  chk_gf_range: assert property (gf_wr |=> gf_reject ==
    ($past(gf_val) < `TTS_GF_MIN || $past(gf_val) > `TTS_GF_MAX))
    else $error("gage factor range check wrong");
  chk_sens_scale: assert property (sens_wr && !gf_wr |=> scale_out == $past(sens_scale))
    else $error("scale not recomputed");
  chk_unit_keep: assert property (unit_wr && !gf_wr && !sens_wr |=> $stable(scale_out))
    else $error("unit change moved the scale");
  cov_cal_end: cover property ($fell(cal_busy));
  cov_send: cover property (send_one);
  cov_reject: cover property ($rose(gf_reject));
endmodule : tts_top_asserts
bind tts_top tts_top_asserts #(.CAL_CYC(CAL_CYC)) u_asserts (.sys_clk(sys_clk), .rstn(rstn),
  .req_offset(req_offset), .req_zero(req_zero), .gf_wr(gf_wr), .gf_val(gf_val),
  .sens_wr(sens_wr), .sens_scale(sens_scale), .unit_wr(unit_wr), .tx_enable(tx_enable),
  .aout_valid(aout_valid), .cal_busy(cal_busy), .send_one(send_one), .gf_reject(gf_reject),
  .meas_out(meas_out), .scale_out(scale_out));
`default_nettype wire

// ---- test/tts_top_tb.sv ----
// Self-checking bench of the tare and threshold switch.
`default_nettype none
module tts_top_tb
  import tts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {
    logic [23:0] m;
    logic a1;
    logic a2;
  } tts_row_t;
  localparam int QC = 20;
  localparam int CC = 50;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic logger_en = 1'b0;
  logic req_offset = 1'b0;
  logic req_zero = 1'b0;
  logic gf_wr = 1'b0;
  logic sens_wr = 1'b0;
  logic unit_wr = 1'b0;
  logic press = 1'b0;
  logic emit_two = 1'b0;
  logic [7:0] press_len = 8'h0A;
  logic [31:0] gf_val = 32'h0;
  logic [31:0] sens_scale = 32'h0;
  logic [7:0] unit_val = 8'h00;
  logic [7:0] sg_unit_val = 8'h5A;
  tts_meas_t meas_in = '0;
  tts_thr_wr_t thr_wr = '0;
  tts_meas_t meas_out;
  logic tare_pin, sw1, sw2, tx_en, aout_v, busy, send_one, gf_rej, r1, r2;
  logic [31:0] scale_out;
  logic [7:0] unit_out;
  int failures = 0;
  int comparisons = 0;
  int n;
  tts_row_t rows[10] = '{'{24'h00000A, 1'b0, 1'b0}, '{24'h00003C, 1'b0, 1'b1},
    '{24'h000064, 1'b0, 1'b0}, '{24'h000065, 1'b1, 1'b0}, '{24'h000046, 1'b1, 1'b1},
    '{24'h000032, 1'b1, 1'b1}, '{24'h000031, 1'b0, 1'b1}, '{24'h000050, 1'b0, 1'b1},
    '{24'h000051, 1'b0, 1'b0}, '{24'h000014, 1'b0, 1'b1}};
  tts_top #(.QUAL_CYC(QC), .CAL_CYC(CC)) DUT (.sys_clk(sys_clk), .rstn(rstn),
    .tare_pin(tare_pin), .logger_en(logger_en), .meas_in(meas_in), .req_offset(req_offset),
    .req_zero(req_zero), .thr_wr(thr_wr), .gf_wr(gf_wr), .gf_val(gf_val), .sens_wr(sens_wr),
    .sens_scale(sens_scale), .unit_wr(unit_wr), .unit_val(unit_val),
    .sg_unit_val(sg_unit_val), .switch_out_one(sw1), .switch_out_two(sw2), .tx_enable(tx_en),
    .aout_valid(aout_v), .cal_busy(busy), .send_one(send_one), .gf_reject(gf_rej),
    .meas_out(meas_out), .scale_out(scale_out), .unit_out(unit_out));
  tts_far_side u_far (.sys_clk(sys_clk), .press(press), .press_len(press_len), .sw_one(sw1),
    .sw_two(sw2), .emit_one(1'b0), .emit_two(emit_two), .tare_pin(tare_pin),
    .relay_one(r1), .relay_two(r2));
  // Free-running system clock.
  always #25 sys_clk = ~sys_clk;
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
  endtask : tick
  task automatic chk1(input logic a, input logic e);
    comparisons++;
    if (a !== e)
    begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk1
  task automatic chkv(input logic [31:0] a, input logic [31:0] e);
    comparisons++;
    if (a !== e)
    begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chkv
  task automatic sample(input logic [23:0] v);
    @(posedge sys_clk);
    meas_in <= '{1'b1, v};
    @(posedge sys_clk);
    meas_in.valid <= 1'b0;
    #1;
  endtask : sample
  task automatic thr(input logic [1:0] c, input tts_thr_field_t f, input logic [23:0] v);
    @(posedge sys_clk);
    thr_wr <= '{1'b1, c, f, v};
    @(posedge sys_clk);
    thr_wr.valid <= 1'b0;
  endtask : thr
  // Pulses press, offset, zero, gage factor, scale and unit strobes.
  task automatic go(input logic [5:0] m);
    @(posedge sys_clk);
    {press, req_offset, req_zero, gf_wr, sens_wr, unit_wr} <= m;
    @(posedge sys_clk);
    {press, req_offset, req_zero, gf_wr, sens_wr, unit_wr} <= 6'h00;
  endtask : go
  task automatic wait_for(input logic e, input int lim);
    #1;
    n = 0;
    while (busy !== e && n < lim)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk1(busy, e);
  endtask : wait_for
  task automatic gfw(input logic [31:0] v, input logic e);
    @(posedge sys_clk);
    gf_val <= v;
    go(6'h04);
    tick(1);
    #1;
    chk1(gf_rej, e);
    if (!e)
      chkv({24'h0, unit_out}, {24'h0, sg_unit_val});
  endtask : gfw
  task automatic final_report;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : final_report
  // Cuts a hung run short.
  initial
  begin
    tick(5000);
    failures++;
    final_report();
  end
  // Main sequence.
  initial
  begin
    tick(2);
    #1;
    chk1(sw1, 1'b1);
    chk1(tx_en, 1'b0);
    @(posedge sys_clk);
    rstn <= 1'b1;
    thr(2'h0, TTS_SET_ON, 24'h000064);
    thr(2'h0, TTS_SET_OFF, 24'h000032);
    thr(2'h1, TTS_SET_ON, 24'h000050);
    thr(2'h1, TTS_SET_OFF, 24'h000014);
    thr(2'h1, TTS_SET_MODE, 24'h000001);
    thr(2'h1, TTS_SET_INV, 24'h000001);
    emit_two <= 1'b1;
    foreach (rows[i])
    begin
      sample(rows[i].m);
      tick(2);
      #1;
      chk1(r1, rows[i].a1);
      chk1(r2, rows[i].a2);
    end
    $display("threshold rows done");
    sample(24'h000064);
    go(6'h10);
    wait_for(1'b1, 3);
    chk1(tx_en | aout_v, 1'b0);
    wait_for(1'b0, CC + 2);
    chk1(tx_en, 1'b1);
    sample(24'h000096);
    chkv({8'h00, meas_out.value}, 32'h00000032);
    sample(24'h7FFFFF);
    go(6'h10);
    wait_for(1'b1, 3);
    wait_for(1'b0, CC + 4);
    sample(24'h7FFFFF);
    chk1(meas_out.value > 24'sh333300 && meas_out.value < 24'sh333400, 1'b1);
    go(6'h08);
    wait_for(1'b1, 3);
    wait_for(1'b0, CC + 2);
    sample(24'h7FFFFF);
    chkv({8'h00, meas_out.value}, 32'h00000000);
    $display("serial calibration done");
    sample(24'h0000C8);
    go(6'h20);
    tick(40);
    #1;
    chk1(busy, 1'b0);
    @(posedge sys_clk);
    press_len <= 8'h28;
    go(6'h20);
    wait_for(1'b1, QC + 10);
    chk1(n >= QC, 1'b1);
    wait_for(1'b0, CC + 2);
    sample(24'h0000C8);
    chkv({8'h00, meas_out.value}, 32'h0);
    @(posedge sys_clk);
    logger_en <= 1'b1;
    tick(50);
    go(6'h20);
    n = 0;
    while (send_one !== 1'b1 && n < QC + 10)
    begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    chk1(send_one, 1'b1);
    chk1(busy, 1'b0);
    $display("tare done");
    gfw(32'h00000013, 1'b1);
    gfw(32'h00000014, 1'b0);
    gfw(32'h000064C9, 1'b1);
    gfw(32'h000064C8, 1'b0);
    @(posedge sys_clk);
    sens_scale <= 32'h00020000;
    unit_val <= 8'h21;
    go(6'h02);
    tick(1);
    #1;
    chkv(scale_out, 32'h00020000);
    go(6'h01);
    tick(1);
    #1;
    chkv({24'h0, unit_out}, 32'h00000021);
    chkv(scale_out, 32'h00020000);
    @(posedge sys_clk);
    rstn <= 1'b0;
    tick(2);
    #1;
    chkv(scale_out, 32'h00010000);
    chk1(sw2, 1'b1);
    $display("settings and reset done");
    final_report();
  end
endmodule : tts_top_tb
`default_nettype wire
